/* src/ubp_defines.svh */
// Constants for the baud generator and power-mode block.
// Assumes a 32-bit AXI4-Lite register window with word-aligned registers.
`ifndef UBP_DEFINES_SVH
`define UBP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UBP_OFS_DIVISOR 8'h00
`define UBP_OFS_MODE 8'h04
`define UBP_OFS_STATUS 8'h08
`define UBP_OFS_IRQ_STAT 8'h0C
`define UBP_OFS_IRQ_MASK 8'h10
`define UBP_OFS_POWER 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UBP_MODE_ENABLE 15
`define UBP_MODE_STOP_IDLE 13
`define UBP_MODE_WAKE 7
`define UBP_MODE_CAPTURE 5
`define UBP_STAT_RXSEL_LO 6
`define UBP_STAT_RX_IDLE 4
`define UBP_STAT_TX_BUSY 8
`define UBP_IRQ_RX 0
`define UBP_IRQ_TX_ABORT 1
`define UBP_IRQ_RX_ABORT 2

// ----------------------------------------------------------------------------
// Reset values and oversampling factor
// ----------------------------------------------------------------------------
`define UBP_RST_DIVISOR 16'h0000
`define UBP_RST_MODE 16'h0000
`define UBP_RST_RXSEL 2'h0
`define UBP_RST_MASK 3'h0
`define UBP_OVERSAMPLE 16

`endif

/* src/ubp_pkg.sv */
// Types shared by the baud generator and power-mode block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package ubp_pkg;
    // Power states, one-hot
    typedef enum logic [2:0] {
        UBP_RUN = 3'b001,
        UBP_HALT = 3'b010,
        UBP_SLEEP = 3'b100
    } ubp_power_t;

    // Mode register fields that steer the logic
    typedef struct packed {
        logic port_enable;
        logic stop_in_idle;
        logic wake_enable;
        logic capture_link;
    } ubp_mode_t;

    // Events that raise sticky interrupt bits
    typedef struct packed {
        logic rx_abort;
        logic tx_abort;
        logic rx_edge;
    } ubp_event_t;
endpackage : ubp_pkg

`default_nettype wire

/* src/ubp_top.sv */
// Baud generator, power-mode handling and register slave for a serial port.
// Assumes framing logic outside reports busy flags and its transmit line level.
//
// How it works
// - A 16-bit divisor register is readable and writable over the bus, any value 0 to 65535.
// - The bit rate is the clock rate over sixteen times the divisor plus one.
// - An option routes the receive pin to a capture output for start-bit timing by software.
// - In Sleep every module clock enable and the tick are stopped and held low.
// - Sleep entry during transmission aborts it and forces the transmit pin high.
// - Sleep entry during reception aborts it.
// - Sleep leaves the divisor and the mode, select and mask registers untouched; entry during a transfer sets its abort status bit.
// - With wake set, a receive falling edge in Sleep raises the receive interrupt whatever the select bits say.
// - That event wakes the device only when the receive interrupt is enabled.
// - No wake interrupt is made while the port is disabled.
// - In Idle the module runs when stop-in-idle is 0 and halts when it is 1.
`include "ubp_defines.svh"
`default_nettype none

module ubp_top (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // AXI4-Lite write channels
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read channels
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Device power state
    input wire logic SLEEP,
    input wire logic IDLE,
    // Framing logic hooks
    input wire logic TX_BUSY,
    input wire logic RX_BUSY,
    input wire logic TX_LINE,
    output logic TICK16,
    output logic MOD_CLK_EN,
    output logic TX_ABORT,
    output logic RX_ABORT,
    // Pins and capture link
    input wire logic SERIAL_RX_PIN,
    output logic SERIAL_TX_PIN,
    output logic CAPTURE_IN,
    // Interrupt and wake
    output logic IRQ,
    output logic WAKE_REQ
);
    import ubp_pkg::*;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [15:0] baud_divisor;
    ubp_mode_t mode;
    logic [1:0] rx_irq_select;
    ubp_event_t irq_status;
    ubp_event_t irq_mask;
    ubp_power_t pstate;
    ubp_power_t next_pstate;
    logic [15:0] div_cnt;
    logic rx_prev;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic addr_ok_w;
    logic [31:0] rd_mux;
    logic addr_ok_r;
    logic running;
    logic sleep_entry;
    ubp_event_t events;
    ubp_event_t w1c;

    assign do_write = aw_got && w_got && !S_AXI_BVALID;
    assign addr_ok_w = aw_addr == `UBP_OFS_DIVISOR || aw_addr == `UBP_OFS_MODE ||
                       aw_addr == `UBP_OFS_STATUS || aw_addr == `UBP_OFS_IRQ_STAT ||
                       aw_addr == `UBP_OFS_IRQ_MASK || aw_addr == `UBP_OFS_POWER;

    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    // Address and data are taken in either order; response follows both.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (S_AXI_AWREADY && S_AXI_AWVALID) begin
                aw_got <= 1'b1;
                aw_addr <= {S_AXI_AWADDR[7:2], 2'b00};
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WREADY && S_AXI_WVALID) begin
                w_got <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= addr_ok_w ? RESP_OKAY : RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    // None of these is touched by the power state, so Sleep keeps them all.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            baud_divisor <= `UBP_RST_DIVISOR;
            mode <= '0;
            rx_irq_select <= `UBP_RST_RXSEL;
            irq_mask <= `UBP_RST_MASK;
        end else if (do_write) begin
            case (aw_addr)
                `UBP_OFS_DIVISOR: begin
                    if (w_strb[0]) baud_divisor[7:0] <= w_data[7:0];
                    if (w_strb[1]) baud_divisor[15:8] <= w_data[15:8];
                end
                `UBP_OFS_MODE: begin
                    if (w_strb[1]) mode.port_enable <= w_data[`UBP_MODE_ENABLE];
                    if (w_strb[1]) mode.stop_in_idle <= w_data[`UBP_MODE_STOP_IDLE];
                    if (w_strb[0]) mode.wake_enable <= w_data[`UBP_MODE_WAKE];
                    if (w_strb[0]) mode.capture_link <= w_data[`UBP_MODE_CAPTURE];
                end
                `UBP_OFS_STATUS: begin
                    if (w_strb[0]) rx_irq_select <= w_data[`UBP_STAT_RXSEL_LO +: 2];
                end
                `UBP_OFS_IRQ_MASK: begin
                    if (w_strb[0]) irq_mask <= w_data[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        addr_ok_r = 1'b1;
        case ({S_AXI_ARADDR[7:2], 2'b00})
            `UBP_OFS_DIVISOR: rd_mux[15:0] = baud_divisor;
            `UBP_OFS_MODE: begin
                rd_mux[`UBP_MODE_ENABLE] = mode.port_enable;
                rd_mux[`UBP_MODE_STOP_IDLE] = mode.stop_in_idle;
                rd_mux[`UBP_MODE_WAKE] = mode.wake_enable;
                rd_mux[`UBP_MODE_CAPTURE] = mode.capture_link;
            end
            `UBP_OFS_STATUS: begin
                rd_mux[`UBP_STAT_RXSEL_LO +: 2] = rx_irq_select;
                rd_mux[`UBP_STAT_RX_IDLE] = !RX_BUSY;
                rd_mux[`UBP_STAT_TX_BUSY] = TX_BUSY;
            end
            `UBP_OFS_IRQ_STAT: rd_mux[2:0] = irq_status;
            `UBP_OFS_IRQ_MASK: rd_mux[2:0] = irq_mask;
            `UBP_OFS_POWER: rd_mux[2:0] = pstate;
            default: addr_ok_r = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARREADY && S_AXI_ARVALID) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= addr_ok_r ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------------
    always_comb begin
        case (1'b1)
            SLEEP: next_pstate = UBP_SLEEP;
            IDLE && mode.stop_in_idle: next_pstate = UBP_HALT;
            default: next_pstate = UBP_RUN;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pstate <= UBP_RUN;
        end else begin
            pstate <= next_pstate;
        end
    end

    assign running = mode.port_enable && next_pstate == UBP_RUN;
    assign sleep_entry = SLEEP && pstate != UBP_SLEEP;

    // ------------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------------
    // The counter freezes rather than resets when stopped, so a short Idle
    // halt resumes mid-period instead of stretching the bit.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            div_cnt <= 16'h0000;
            TICK16 <= 1'b0;
            MOD_CLK_EN <= 1'b0;
        end else begin
            MOD_CLK_EN <= running;
            TICK16 <= 1'b0;
            if (running) begin
                if (div_cnt == 16'h0000) begin
                    div_cnt <= baud_divisor;
                    TICK16 <= 1'b1;
                end else begin
                    div_cnt <= div_cnt - 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pins, aborts and capture link
    // ------------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            SERIAL_TX_PIN <= 1'b1;
            CAPTURE_IN <= 1'b1;
            TX_ABORT <= 1'b0;
            RX_ABORT <= 1'b0;
            rx_prev <= 1'b1;
        end else begin
            SERIAL_TX_PIN <= (SLEEP || !mode.port_enable) ? 1'b1 : TX_LINE;
            CAPTURE_IN <= mode.capture_link ? SERIAL_RX_PIN : 1'b1;
            TX_ABORT <= sleep_entry && TX_BUSY;
            RX_ABORT <= sleep_entry && RX_BUSY;
            rx_prev <= SERIAL_RX_PIN;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // Wake edge ignores the receive select bits and needs the port enabled.
    assign events.rx_edge = pstate == UBP_SLEEP && mode.wake_enable && mode.port_enable &&
                            rx_prev && !SERIAL_RX_PIN;
    assign events.tx_abort = sleep_entry && TX_BUSY;
    assign events.rx_abort = sleep_entry && RX_BUSY;
    assign w1c = (do_write && aw_addr == `UBP_OFS_IRQ_STAT && w_strb[0]) ? w_data[2:0] : '0;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_status <= '0;
            IRQ <= 1'b0;
            WAKE_REQ <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~w1c) | events;
            IRQ <= |(irq_status & irq_mask);
            WAKE_REQ <= pstate == UBP_SLEEP && mode.port_enable &&
                        irq_status.rx_edge && irq_mask.rx_edge;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_tick_period: assert property (@(posedge MCLK) disable iff (!RST_N)
        TICK16 && $stable(baud_divisor) |-> div_cnt == baud_divisor)
        else $error("divisor counter did not reload after tick");
    a_divzero_rate: assert property (@(posedge MCLK) disable iff (!RST_N)
        baud_divisor == 16'h0000 && div_cnt == 16'h0000 && running ##1 running |=> TICK16)
        else $error("zero divisor did not tick every cycle");
    a_sleep_clocks: assert property (@(posedge MCLK) disable iff (!RST_N)
        pstate == UBP_SLEEP |-> !TICK16 && !MOD_CLK_EN)
        else $error("clock active during sleep");
    a_tx_idle_high: assert property (@(posedge MCLK) disable iff (!RST_N)
        $past(SLEEP) |-> SERIAL_TX_PIN)
        else $error("transmit pin not high in sleep");
    a_rx_abort: assert property (@(posedge MCLK) disable iff (!RST_N)
        SLEEP && pstate == UBP_RUN && RX_BUSY |=> RX_ABORT)
        else $error("reception not aborted on sleep entry");
    a_divisor_kept: assert property (@(posedge MCLK) disable iff (!RST_N)
        !do_write ##1 pstate == UBP_SLEEP |-> $stable(baud_divisor) && $stable(mode))
        else $error("register changed by sleep");
    a_wake_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
        events.rx_edge |=> irq_status.rx_edge ##1 (IRQ || !irq_mask.rx_edge))
        else $error("wake edge did not raise receive interrupt");
    a_wake_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
        WAKE_REQ |-> $past(irq_mask.rx_edge) && $past(mode.port_enable))
        else $error("wake without enabled receive interrupt");
    a_idle_halt: assert property (@(posedge MCLK) disable iff (!RST_N)
        IDLE && !SLEEP && mode.stop_in_idle |=> !TICK16 && !MOD_CLK_EN)
        else $error("module ran in idle with stop set");
    a_capture_route: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode.capture_link |=> CAPTURE_IN == $past(SERIAL_RX_PIN))
        else $error("capture link does not follow receive pin");
endmodule : ubp_top

`default_nettype wire

/* testbench/ubp_remote.sv */
// Remote serial transceiver model: drives the receive line of the port.
// Assumes the bench asks for one start bit by pulsing send_start for a cycle.
`default_nettype none

module ubp_remote #(
    parameter int START_LEN = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request from the bench
    input wire logic send_start,
    // Serial line towards the port
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ns;

    int left;

    // Line idles high between frames; a start bit is a low level of START_LEN cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left <= 0;
        end else if (send_start) begin
            left <= START_LEN;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_line <= 1'b1;
        end else begin
            rx_line <= !(send_start || left > 1);
        end
    end
endmodule : ubp_remote

`default_nettype wire

/* testbench/test_uart_baud_and_power_modes.sv */
// Self-checking bench for the baud generator and power-mode block.
// Assumes the design package, defines header and remote model are compiled first.
`include "ubp_defines.svh"
`default_nettype none

module test_uart_baud_and_power_modes;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
        logic [1:0] resp;
    } ubp_row_t;

    logic mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic sleep, idle, tx_busy, rx_busy, tx_line, tick, clk_en, tx_abort, rx_abort;
    logic rx_pin, tx_pin, cap, irq, wake_req, send_start;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int err_total, checked;
    ubp_row_t rows[6];
    int divs[4] = '{0, 2, 5, 9};

    ubp_top uut (
        .MCLK(mclk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
        .SLEEP(sleep), .IDLE(idle), .TX_BUSY(tx_busy), .RX_BUSY(rx_busy), .TX_LINE(tx_line),
        .TICK16(tick), .MOD_CLK_EN(clk_en), .TX_ABORT(tx_abort), .RX_ABORT(rx_abort),
        .SERIAL_RX_PIN(rx_pin), .SERIAL_TX_PIN(tx_pin), .CAPTURE_IN(cap),
        .IRQ(irq), .WAKE_REQ(wake_req)
    );

    ubp_remote #(.START_LEN(4)) remote (.clk(mclk), .rst_n(rst_n), .send_start(send_start), .rx_line(rx_pin));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_up(input string what);
        err_total++;
        $display("wrong value %s expected an answer seen none", what);
        complete_run();
    endtask : give_up

    // Both channels offered together; each dropped at its own handshake
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) give_up("write response");
        r = bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) give_up("read response");
        d = rdata;
        r = rresp;
    endtask : axi_rd

    task automatic wait_hi(ref logic s, input string what);
        int n;
        for (n = 0; n < 20 && s !== 1'b1; n++) @(negedge mclk);
        if (s !== 1'b1) give_up(what);
    endtask : wait_hi

    // Old divisor may be large, so the first tick is allowed a long wait;
    // only a tick seen after the call has reloaded from the new divisor
    task automatic tick_gap(output int g);
        int n;
        g = 0;
        for (n = 0; n < 5000; n++) begin
            @(negedge mclk);
            if (tick === 1'b1) break;
        end
        if (n == 5000) give_up("first tick");
        do begin
            @(negedge mclk);
            g++;
        end while (tick !== 1'b1 && g < 200);
    endtask : tick_gap

    task automatic tick_count(output int c);
        c = 0;
        repeat (20) begin
            @(negedge mclk);
            if (tick === 1'b1) c++;
        end
    endtask : tick_count

    task automatic kick();
        @(posedge mclk);
        send_start <= 1'b1;
        @(posedge mclk);
        send_start <= 1'b0;
    endtask : kick

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(what, exp, d);
    endtask : rd_check

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int c;
        err_total = 0;
        checked = 0;
        {rst_n, awvalid, wvalid, arvalid, sleep, idle, tx_busy, rx_busy, send_start} = '0;
        tx_line = 1'b1;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        rows[0] = '{`UBP_OFS_DIVISOR, 32'h0000FFFF, 32'h0000FFFF, 2'h0};
        rows[1] = '{`UBP_OFS_DIVISOR, 32'h00001234, 32'h00001234, 2'h0};
        rows[2] = '{`UBP_OFS_MODE, 32'h000080A0, 32'h000080A0, 2'h0};
        rows[3] = '{`UBP_OFS_STATUS, 32'h000000C0, 32'h000000D0, 2'h0};
        rows[4] = '{`UBP_OFS_POWER, 32'h00000004, 32'h00000001, 2'h0};
        rows[5] = '{8'h18, 32'h00000005, 32'h00000000, 2'h2};
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        check("tx pin in reset", 1, tx_pin);
        check("capture in reset", 1, cap);
        check("irq in reset", 0, irq);
        @(posedge mclk);
        rst_n <= 1'b1;
        rd_check(`UBP_OFS_DIVISOR, 0, "divisor after reset");
        foreach (rows[i]) begin
            axi_wr(rows[i].addr, rows[i].wdata, r);
            check("write response", rows[i].resp, r);
            axi_rd(rows[i].addr, d, r);
            check("read data", rows[i].rexp, d);
            check("read response", rows[i].resp, r);
        end
        foreach (divs[i]) begin
            axi_wr(`UBP_OFS_DIVISOR, divs[i], r);
            tick_gap(c);
            check("tick gap", divs[i] + 1, c);
        end
        @(posedge mclk);
        idle <= 1'b1;
        tick_gap(c);
        check("tick gap in idle", 10, c);
        check("clock enable in idle", 1, clk_en);
        axi_wr(`UBP_OFS_MODE, 32'h0000A0A0, r);
        tick_count(c);
        check("ticks when halted", 0, c);
        check("clock enable when halted", 0, clk_en);
        @(posedge mclk);
        idle <= 1'b0;
        axi_wr(`UBP_OFS_MODE, 32'h000080A0, r);
        kick();
        repeat (2) @(negedge mclk);
        check("capture follows low line", 0, cap);
        repeat (7) @(negedge mclk);
        check("capture follows high line", 1, cap);
        axi_wr(`UBP_OFS_IRQ_MASK, 1, r);
        axi_wr(`UBP_OFS_DIVISOR, 2, r);
        @(posedge mclk);
        tx_busy <= 1'b1;
        rx_busy <= 1'b1;
        tx_line <= 1'b0;
        repeat (2) @(negedge mclk);
        check("tx pin follows line", 0, tx_pin);
        @(posedge mclk);
        sleep <= 1'b1;
        wait_hi(tx_abort, "transmit abort");
        check("receive abort", 1, rx_abort);
        tick_count(c);
        check("ticks in sleep", 0, c);
        check("clock enable in sleep", 0, clk_en);
        check("tx pin in sleep", 1, tx_pin);
        rd_check(`UBP_OFS_POWER, 4, "power state");
        rd_check(`UBP_OFS_DIVISOR, 2, "divisor in sleep");
        rd_check(`UBP_OFS_MODE, 32'h000080A0, "mode in sleep");
        rd_check(`UBP_OFS_STATUS, 32'h000001C0, "status in sleep");
        check("irq before edge", 0, irq);
        kick();
        wait_hi(irq, "receive interrupt");
        check("wake request", 1, wake_req);
        rd_check(`UBP_OFS_IRQ_STAT, 7, "event status");
        axi_wr(`UBP_OFS_IRQ_STAT, 7, r);
        repeat (3) @(negedge mclk);
        check("irq after clear", 0, irq);
        rd_check(`UBP_OFS_IRQ_STAT, 0, "status after clear");
        axi_wr(`UBP_OFS_IRQ_MASK, 0, r);
        kick();
        repeat (8) @(negedge mclk);
        check("wake when masked", 0, wake_req);
        check("irq when masked", 0, irq);
        rd_check(`UBP_OFS_IRQ_STAT, 1, "masked event status");
        axi_wr(`UBP_OFS_IRQ_STAT, 1, r);
        axi_wr(`UBP_OFS_IRQ_MASK, 1, r);
        axi_wr(`UBP_OFS_MODE, 32'h000000A0, r);
        kick();
        repeat (8) @(negedge mclk);
        check("wake when disabled", 0, wake_req);
        rd_check(`UBP_OFS_IRQ_STAT, 0, "status when disabled");
        @(posedge mclk);
        sleep <= 1'b0;
        complete_run();
    end
endmodule : test_uart_baud_and_power_modes

`default_nettype wire
